// ===== common/rtcc_map.svh
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH

// register offsets
`define RTCC_OFS_SECOND 4'h0
`define RTCC_OFS_MINUTE 4'h1
`define RTCC_OFS_HOUR 4'h2
`define RTCC_OFS_WEEKDAY 4'h3
`define RTCC_OFS_MDAY 4'h4
`define RTCC_OFS_MONTH 4'h5
`define RTCC_OFS_YEAR 4'h6
`define RTCC_OFS_TRIM 4'h7

// field positions
`define RTCC_HOUR_PM_BIT 5
`define RTCC_CENTURY_BIT 7
`define RTCC_TRIM_INTERVAL_BIT 7
`define RTCC_TRIM_DIRECTION_BIT 6

// reset values
`define RTCC_TRIM_RST 8'h00
`define RTCC_TIME_RST 8'h00
`define RTCC_MDAY_RST 6'h01
`define RTCC_MONTH_RST 5'h01
`define RTCC_WEEKDAY_RST 3'h0

// calendar limits
`define RTCC_SEC_LAST 7'h59
`define RTCC_MIN_LAST 7'h59
`define RTCC_HOUR24_LAST 6'h23
`define RTCC_HOUR12_MIDNIGHT 5'h12
`define RTCC_HOUR12_ELEVEN 5'h11
`define RTCC_WEEKDAY_LAST 3'h6
`define RTCC_MONTH_LAST 5'h12
`define RTCC_YEAR_LAST 8'h99

// timing
`define RTCC_CLK_PERIOD_NS 5
`define RTCC_ALARM_DELAY_NS 31000
`define RTCC_ALARM_DELAY_CYC ((`RTCC_ALARM_DELAY_NS + `RTCC_CLK_PERIOD_NS - 1) / `RTCC_CLK_PERIOD_NS)
`define RTCC_PRESCALE_DIV 32768
`define RTCC_PRESCALE_W 15
`define RTCC_ALARM_CNT_W 16

`endif

// ===== common/rtcc_pkg.sv
`include "rtcc_map.svh"

package rtcc_pkg;

  typedef enum logic [0:0] {
    RTCC_AL_IDLE = 1'b0,
    RTCC_AL_DELAY = 1'b1
  } rtcc_alarm_state_e;

  typedef struct packed {
    rtcc_alarm_state_e state;
    logic [`RTCC_ALARM_CNT_W-1:0] cnt;
    logic match_d;
    logic flag;
  } rtcc_alarm_s;

  typedef struct packed {
    logic [`RTCC_PRESCALE_W-1:0] presc;
    logic [6:0] second;
    logic [6:0] minute;
    logic [5:0] hour;
    logic [2:0] weekday;
    logic [5:0] mday;
    logic [4:0] month;
    logic century;
    logic [7:0] year;
    logic [7:0] trim;
    logic power_on_flag;
    logic [7:0] rdata;
  } rtcc_core_s;

endpackage

// ===== rtl/rtcc_alarm.sv
`timescale 1ns/1ps
`include "rtcc_map.svh"

module rtcc_alarm
  import rtcc_pkg::*;
#(
  parameter int unsigned DELAY_CYC = `RTCC_ALARM_DELAY_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic match_i,
  input wire logic flag_wr0_i,
  output logic flag_o
);

  localparam logic [`RTCC_ALARM_CNT_W-1:0] DELAY_LOAD = `RTCC_ALARM_CNT_W'(DELAY_CYC - 1);

  rtcc_alarm_s st_r;
  rtcc_alarm_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.match_d = match_i;
    if (flag_wr0_i) begin
      st_nxt.flag = 1'b0;
    end
    unique case (st_r.state)
      RTCC_AL_IDLE: begin
        // new match only on the rising edge, so one preset time fires once
        if (enable_i && match_i && !st_r.match_d) begin
          st_nxt.state = RTCC_AL_DELAY;
          st_nxt.cnt = DELAY_LOAD;
        end
      end
      RTCC_AL_DELAY: begin
        if (st_r.cnt == '0) begin
          st_nxt.state = RTCC_AL_IDLE;
          st_nxt.flag = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
    endcase
    if (!enable_i) begin
      st_nxt.state = RTCC_AL_IDLE;
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '{state: RTCC_AL_IDLE, cnt: '0, match_d: 1'b0, flag: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag & enable_i;

endmodule // rtcc_alarm

// ===== rtl/rtcc_core.sv
`timescale 1ns/1ps
`include "rtcc_map.svh"

module rtcc_core
  import rtcc_pkg::*;
#(
  parameter int unsigned ALARM_DELAY_CYC = `RTCC_ALARM_DELAY_CYC,
  parameter int unsigned PRESCALE_DIV = `RTCC_PRESCALE_DIV
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic tick_32k_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic hour_mode_24_i,
  input wire logic weekly_alarm_enable_i,
  input wire logic daily_alarm_enable_i,
  input wire logic weekly_alarm_match_i,
  input wire logic daily_alarm_match_i,
  input wire logic weekly_alarm_flag_wr0_i,
  input wire logic daily_alarm_flag_wr0_i,
  input wire logic power_on_detect_i,
  input wire logic power_on_flag_wr0_i,
  output logic [7:0] reg_rdata_o,
  output logic [6:0] minute_o,
  output logic [5:0] hour_o,
  output logic [2:0] weekday_o,
  output logic second_tick_o,
  output logic weekly_alarm_flag_o,
  output logic daily_alarm_flag_o,
  output logic power_on_flag_o,
  output logic irq_out_n_o
);

  localparam logic [`RTCC_PRESCALE_W-1:0] PRESC_LAST = `RTCC_PRESCALE_W'(PRESCALE_DIV - 1);

  // two-digit BCD increment, digit carry at 9
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // BCD year divisible by four, 00 included
  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    if (y[4]) begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return r;
  endfunction

  // last day of a BCD month
  function automatic logic [5:0] month_last(input logic [4:0] m, input logic leap);
    logic [5:0] r;
    unique case (m)
      5'h02: r = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: r = 6'h30;
      default: r = 6'h31;
    endcase
    return r;
  endfunction

  rtcc_core_s st_r;
  rtcc_core_s st_nxt;
  logic sec_tick;
  logic weekly_flag;
  logic daily_flag;

  assign sec_tick = tick_32k_i && (st_r.presc == PRESC_LAST);

  always_comb begin
    logic c_sec;
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    logic [7:0] tmp;
    logic [4:0] h12;
    c_sec = 1'b0;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    tmp = 8'h00;
    h12 = 5'h00;
    st_nxt = st_r;

    if (tick_32k_i) begin
      st_nxt.presc = sec_tick ? '0 : st_r.presc + 1'b1;
    end

    if (sec_tick) begin
      if (st_r.second == `RTCC_SEC_LAST) begin
        st_nxt.second = '0;
        c_sec = 1'b1;
      end else begin
        tmp = bcd_inc({1'b0, st_r.second});
        st_nxt.second = tmp[6:0];
      end
    end

    if (c_sec) begin
      if (st_r.minute == `RTCC_MIN_LAST) begin
        st_nxt.minute = '0;
        c_min = 1'b1;
      end else begin
        tmp = bcd_inc({1'b0, st_r.minute});
        st_nxt.minute = tmp[6:0];
      end
    end

    if (c_min) begin
      if (hour_mode_24_i) begin
        // bit 5 is the tens-two digit here
        if (st_r.hour == `RTCC_HOUR24_LAST) begin
          st_nxt.hour = '0;
          c_hour = 1'b1;
        end else begin
          tmp = bcd_inc({2'b00, st_r.hour});
          st_nxt.hour = tmp[5:0];
        end
      end else begin
        // bit 5 is PM, low five bits run 12,01..11
        h12 = st_r.hour[4:0];
        if (h12 == `RTCC_HOUR12_MIDNIGHT) begin
          st_nxt.hour = {st_r.hour[`RTCC_HOUR_PM_BIT], 5'h01};
        end else if (h12 == `RTCC_HOUR12_ELEVEN) begin
          st_nxt.hour = {~st_r.hour[`RTCC_HOUR_PM_BIT], `RTCC_HOUR12_MIDNIGHT};
          c_hour = st_r.hour[`RTCC_HOUR_PM_BIT];
        end else begin
          tmp = bcd_inc({3'b000, h12});
          st_nxt.hour = {st_r.hour[`RTCC_HOUR_PM_BIT], tmp[4:0]};
        end
      end
    end

    if (c_hour) begin
      if (st_r.weekday == `RTCC_WEEKDAY_LAST) begin
        st_nxt.weekday = '0;
      end else begin
        st_nxt.weekday = st_r.weekday + 3'h1;
      end
      if (st_r.mday == month_last(st_r.month, is_leap(st_r.year))) begin
        st_nxt.mday = `RTCC_MDAY_RST;
        c_day = 1'b1;
      end else begin
        tmp = bcd_inc({2'b00, st_r.mday});
        st_nxt.mday = tmp[5:0];
      end
    end

    if (c_day) begin
      if (st_r.month == `RTCC_MONTH_LAST) begin
        st_nxt.month = `RTCC_MONTH_RST;
        c_mon = 1'b1;
      end else begin
        tmp = bcd_inc({3'b000, st_r.month});
        st_nxt.month = tmp[4:0];
      end
    end

    if (c_mon) begin
      if (st_r.year == `RTCC_YEAR_LAST) begin
        st_nxt.year = '0;
        st_nxt.century = ~st_r.century;
      end else begin
        st_nxt.year = bcd_inc(st_r.year);
      end
    end

    // host writes take priority over a carry in the same cycle
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `RTCC_OFS_SECOND: begin
          st_nxt.second = reg_wdata_i[6:0];
          st_nxt.presc = '0;
        end
        `RTCC_OFS_MINUTE: st_nxt.minute = reg_wdata_i[6:0];
        `RTCC_OFS_HOUR: st_nxt.hour = reg_wdata_i[5:0];
        `RTCC_OFS_WEEKDAY: st_nxt.weekday = reg_wdata_i[2:0];
        `RTCC_OFS_MDAY: st_nxt.mday = reg_wdata_i[5:0];
        `RTCC_OFS_MONTH: begin
          st_nxt.month = reg_wdata_i[4:0];
          st_nxt.century = reg_wdata_i[`RTCC_CENTURY_BIT];
        end
        `RTCC_OFS_YEAR: st_nxt.year = reg_wdata_i;
        `RTCC_OFS_TRIM: st_nxt.trim = reg_wdata_i;
        default: st_nxt.trim = st_nxt.trim;
      endcase
    end

    if (power_on_flag_wr0_i) begin
      st_nxt.power_on_flag = 1'b0;
    end
    // detection wins over a clear in the same cycle
    if (power_on_detect_i) begin
      st_nxt.power_on_flag = 1'b1;
      st_nxt.trim = `RTCC_TRIM_RST;
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `RTCC_OFS_SECOND: st_nxt.rdata = {1'b0, st_r.second};
        `RTCC_OFS_MINUTE: st_nxt.rdata = {1'b0, st_r.minute};
        `RTCC_OFS_HOUR: st_nxt.rdata = {2'b00, st_r.hour};
        `RTCC_OFS_WEEKDAY: st_nxt.rdata = {5'h00, st_r.weekday};
        `RTCC_OFS_MDAY: st_nxt.rdata = {2'b00, st_r.mday};
        `RTCC_OFS_MONTH: st_nxt.rdata = {st_r.century, 2'b00, st_r.month};
        `RTCC_OFS_YEAR: st_nxt.rdata = st_r.year;
        `RTCC_OFS_TRIM: st_nxt.rdata = st_r.trim;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r.presc <= '0;
      st_r.second <= '0;
      st_r.minute <= '0;
      st_r.hour <= '0;
      st_r.weekday <= `RTCC_WEEKDAY_RST;
      st_r.mday <= `RTCC_MDAY_RST;
      st_r.month <= `RTCC_MONTH_RST;
      st_r.century <= 1'b0;
      st_r.year <= `RTCC_TIME_RST;
      st_r.trim <= `RTCC_TRIM_RST;
      st_r.power_on_flag <= 1'b1;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  rtcc_alarm #(
    .DELAY_CYC(ALARM_DELAY_CYC)
  ) u_weekly_alarm (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .enable_i(weekly_alarm_enable_i),
    .match_i(weekly_alarm_match_i),
    .flag_wr0_i(weekly_alarm_flag_wr0_i),
    .flag_o(weekly_flag)
  );

  rtcc_alarm #(
    .DELAY_CYC(ALARM_DELAY_CYC)
  ) u_daily_alarm (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .enable_i(daily_alarm_enable_i),
    .match_i(daily_alarm_match_i),
    .flag_wr0_i(daily_alarm_flag_wr0_i),
    .flag_o(daily_flag)
  );

  assign weekly_alarm_flag_o = weekly_flag;
  assign daily_alarm_flag_o = daily_flag;
  assign irq_out_n_o = ~(weekly_flag | daily_flag);
  assign reg_rdata_o = st_r.rdata;
  assign minute_o = st_r.minute;
  assign hour_o = st_r.hour;
  assign weekday_o = st_r.weekday;
  assign second_tick_o = sec_tick;
  assign power_on_flag_o = st_r.power_on_flag;

endmodule // rtcc_core

// ===== tb/rtcc_core_sva.sv
`timescale 1ns/1ps

module rtcc_core_sva #(
  parameter int unsigned ALARM_DELAY_CYC = 8,
  parameter int unsigned PRESCALE_DIV = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic hour_mode_24_i,
  input wire logic weekly_alarm_enable_i,
  input wire logic daily_alarm_enable_i,
  input wire logic daily_alarm_match_i,
  input wire logic daily_alarm_flag_wr0_i,
  input wire logic power_on_detect_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [6:0] minute_o,
  input wire logic [5:0] hour_o,
  input wire logic [2:0] weekday_o,
  input wire logic second_tick_o,
  input wire logic weekly_alarm_flag_o,
  input wire logic daily_alarm_flag_o,
  input wire logic power_on_flag_o,
  input wire logic irq_out_n_o
);
  localparam int DLY = ALARM_DELAY_CYC + 1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_arm;
    $rose(daily_alarm_match_i) && daily_alarm_enable_i && !daily_alarm_flag_o;
  endsequence
  sequence s_day_roll;
    $changed(weekday_o) && !$past(reg_wr_i);
  endsequence
  alarm_delay_a: assert property (s_arm |-> ##DLY $rose(daily_alarm_flag_o))
    else $error("alarm flag timing wrong");
  flag_clear_a: assert property (daily_alarm_flag_o && daily_alarm_flag_wr0_i |=> !daily_alarm_flag_o)
    else $error("alarm flag not cleared");
  daily_gate_a: assert property (!daily_alarm_enable_i |-> !daily_alarm_flag_o)
    else $error("daily flag set while disabled");
  weekly_gate_a: assert property (!weekly_alarm_enable_i |-> !weekly_alarm_flag_o)
    else $error("weekly flag set while disabled");
  irq_sync_a: assert property (irq_out_n_o == !(weekly_alarm_flag_o || daily_alarm_flag_o))
    else $error("irq out of step with flags");
  minute_step_a: assert property ($changed(minute_o) && !$past(reg_wr_i) |-> $past(second_tick_o) && minute_o[3:0] <= 4'h9)
    else $error("minute moved without carry");
  day_carry_a: assert property (s_day_roll |-> $past(hour_o) == ($past(hour_mode_24_i) ? 6'h23 : 6'h31))
    else $error("day carry from wrong hour");
  week_step_a: assert property (s_day_roll |-> weekday_o == ($past(weekday_o) == 3'h6 ? 3'h0 : $past(weekday_o) + 3'h1))
    else $error("weekday step wrong");
  pon_set_a: assert property (power_on_detect_i |=> power_on_flag_o)
    else $error("power-on flag not set");
  rd_unmap_a: assert property (reg_rd_i && reg_addr_i[3] |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule // rtcc_core_sva

bind rtcc_core rtcc_core_sva #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC), .PRESCALE_DIV(PRESCALE_DIV)) u_sva (.*);

// ===== tb/rtcc_host.sv
`timescale 1ns/1ps

module rtcc_host (
  input wire logic clk_sys_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [3:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 4'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // values are sent as given; t_regs also writes set upper bits, weekday 8'hFE and unmapped address 9
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
endmodule // rtcc_host

// ===== tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import rtcc_pkg::*;
  localparam int DLY = 8;
  localparam int DIV = 4;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic tick = 1'b0;
  logic mode24 = 1'b1;
  logic pon_det = 1'b0;
  logic pon_clr = 1'b0;
  logic [1:0] en = 2'b00;
  logic [1:0] mt = 2'b00;
  logic [1:0] c0 = 2'b00;
  logic [1:0] fl;
  logic [3:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic power_on_flag;
  logic irq_n;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  rtcc_core #(.ALARM_DELAY_CYC(DLY), .PRESCALE_DIV(DIV)) u_rtcc_core (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .tick_32k_i(tick), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .hour_mode_24_i(mode24),
    .weekly_alarm_enable_i(en[1]), .daily_alarm_enable_i(en[0]), .weekly_alarm_match_i(mt[1]),
    .daily_alarm_match_i(mt[0]), .weekly_alarm_flag_wr0_i(c0[1]), .daily_alarm_flag_wr0_i(c0[0]),
    .power_on_detect_i(pon_det), .power_on_flag_wr0_i(pon_clr), .reg_rdata_o(rdata),
    .minute_o(), .hour_o(), .weekday_o(), .second_tick_o(), .weekly_alarm_flag_o(fl[1]),
    .daily_alarm_flag_o(fl[0]), .power_on_flag_o(power_on_flag), .irq_out_n_o(irq_n));

  rtcc_host u_host (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, e);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      tick = 1'b1;
      @(negedge clk_sys_i);
      tick = 1'b0;
    end
  endtask

  task automatic t_pon();
    chk({7'h0, power_on_flag}, 8'h01);
    pon_clr = 1'b1;
    @(negedge clk_sys_i);
    pon_clr = 1'b0;
    chk({7'h0, power_on_flag}, 8'h00);
    u_host.wr(4'h7, 8'hA5);
    pon_det = 1'b1;
    @(negedge clk_sys_i);
    pon_det = 1'b0;
    chk({7'h0, power_on_flag}, 8'h01);
    rc(4'h7, 8'h00);
    $display("power-on test done");
  endtask

  task automatic t_regs();
    logic [7:0] wv [8] = '{8'hD9, 8'hD9, 8'hE3, 8'hFE, 8'hF1, 8'hF2, 8'h99, 8'hA5};
    logic [7:0] ev [8] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h92, 8'h99, 8'hA5};
    for (int i = 0; i < 8; i++) begin
      u_host.wr(4'(i), wv[i]);
      rc(4'(i), ev[i]);
    end
    u_host.wr(4'h9, 8'h55);
    rc(4'h9, 8'h00);
    $display("register test done");
  endtask

  task automatic t_roll();
    logic [23:0] iv [4] = '{24'h022899, 24'h022896, 24'h123199, 24'h043000};
    logic [23:0] xv [4] = '{24'h030199, 24'h022996, 24'h810100, 24'h050100};
    mode24 = 1'b1;
    for (int i = 0; i < 4; i++) begin
      tk(2);
      u_host.wr(4'h0, 8'h59);
      u_host.wr(4'h1, 8'h59);
      u_host.wr(4'h2, 8'h23);
      u_host.wr(4'h3, 8'h06);
      u_host.wr(4'h5, iv[i][23:16]);
      u_host.wr(4'h4, iv[i][15:8]);
      u_host.wr(4'h6, iv[i][7:0]);
      tk(DIV - 1);
      rc(4'h0, 8'h59);
      tk(1);
      rc(4'h0, 8'h00);
      rc(4'h1, 8'h00);
      rc(4'h2, 8'h00);
      rc(4'h3, 8'h00);
      rc(4'h4, xv[i][15:8]);
      rc(4'h5, xv[i][23:16]);
      rc(4'h6, xv[i][7:0]);
    end
    $display("rollover test done");
  endtask

  task automatic t_12h();
    logic [7:0] hv [4] = '{8'h11, 8'h32, 8'h31, 8'h12};
    mode24 = 1'b0;
    u_host.wr(4'h3, 8'h02);
    for (int i = 0; i < 2; i++) begin
      u_host.wr(4'h2, hv[2 * i]);
      u_host.wr(4'h1, 8'h59);
      u_host.wr(4'h0, 8'h59);
      tk(DIV);
      rc(4'h2, hv[2 * i + 1]);
      rc(4'h3, 8'h02 + 8'(i));
    end
    mode24 = 1'b1;
    $display("12-hour test done");
  endtask

  task automatic t_alarm(input int k);
    mt[k] = 1'b1;
    repeat (DLY + 1) @(negedge clk_sys_i);
    chk({6'h0, fl}, 8'h00);
    mt[k] = 1'b0;
    en[k] = 1'b1;
    @(negedge clk_sys_i);
    mt[k] = 1'b1;
    repeat (DLY) @(negedge clk_sys_i);
    chk({6'h0, fl}, 8'h00);
    @(negedge clk_sys_i);
    chk({7'h0, fl[k]}, 8'h01);
    chk({7'h0, irq_n}, 8'h00);
    c0[k] = 1'b1;
    @(negedge clk_sys_i);
    c0[k] = 1'b0;
    chk({6'h0, fl}, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    mt[k] = 1'b0;
    @(negedge clk_sys_i);
    mt[k] = 1'b1;
    repeat (DLY + 1) @(negedge clk_sys_i);
    chk({7'h0, irq_n}, 8'h00);
    @(negedge clk_sys_i);
    chk({7'h0, fl[k]}, 8'h01);
    en[k] = 1'b0;
    @(negedge clk_sys_i);
    chk({6'h0, fl}, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    mt[k] = 1'b0;
    $display("alarm test %0d done", k);
  endtask

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    t_pon();
    t_regs();
    t_roll();
    t_12h();
    t_alarm(0);
    t_alarm(1);
    summarize();
  end
endmodule // tb_top
